// *** logic/sddr_consts.svh ***
// constants for the slave delta diagnostic record block
// assumes inclusion by bare name from the logic folder
`ifndef SDDR_CONSTS_SVH
`define SDDR_CONSTS_SVH
`define SDDR_REC_BYTES      5'd16
`define SDDR_OFS_BASE       4'h0
`define SDDR_OFS_FIX4       4'h4
`define SDDR_OFS_FIX5       4'h5
`define SDDR_OFS_FIX6       4'h6
`define SDDR_OFS_STD        4'h7
`define SDDR_OFS_BSL        4'hb
`define SDDR_OFS_RSVD       4'hf
`define SDDR_FIX4_VAL       8'h60
`define SDDR_FIX5_VAL       8'h00
`define SDDR_FIX6_VAL       8'h40
`define SDDR_RSVD_VAL       8'h00
`define SDDR_GROUP_FAULT_BIT 0
`define SDDR_DIAG_RESET     32'h0000_0000
`define SDDR_ERR_RESET      64'h0
`endif

// *** logic/sddr_pkg.sv ***
// types for the slave delta diagnostic record block
// assumes the consts header is compiled alongside
package sddr_pkg;
  typedef struct packed {
    logic [31:0] b_slaves;
    logic [31:0] std_slaves;
  } sddr_errmap_type;
  typedef struct packed {
    logic       valid;
    logic [3:0] index;
  } sddr_read_req_type;
endpackage : sddr_pkg

// *** logic/sddr_record.sv ***
// slave delta diagnostic record: error bitmap, record read port, interrupt request
// assumes slave status inputs synchronous to sys_clk; host acknowledges each interrupt
`timescale 1ns/1ps
`include "sddr_consts.svh"
module sddr_record #(
  parameter int NUM_SLAVES = 32
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic [NUM_SLAVES-1:0]   std_missing,
  input  wire logic [NUM_SLAVES-1:0]   std_wrong_type,
  input  wire logic [NUM_SLAVES-1:0]   std_unconfigured,
  input  wire logic [NUM_SLAVES-1:0]   b_missing,
  input  wire logic [NUM_SLAVES-1:0]   b_wrong_type,
  input  wire logic [NUM_SLAVES-1:0]   b_unconfigured,
  input  wire logic                    protected_mode,
  input  wire logic                    host_can_accept,
  input  wire logic                    irq_ack,
  input  wire sddr_pkg::sddr_read_req_type rd_req,
  input  wire logic [23:0]             base_diag_extra,
  output logic                         diag_irq,
  output logic [31:0]                  base_diag_copy,
  output logic [7:0]                   rd_data,
  output logic                         rd_valid
);
  ////////////////////////////////////////////////////////////////////////
  sddr_pkg::sddr_errmap_type errmap;
  sddr_pkg::sddr_errmap_type reported_map;
  logic                      reported_fault;
  wire  [2*NUM_SLAVES-1:0]   next_errmap;
  wire  [127:0]              record_flat;
  wire                       any_fault;
  wire                       state_differs;
  wire                       fire;

  genvar g;
  generate
    for (g = 0; g < NUM_SLAVES; g++) begin : g_slave
      // missing, wrong type or unconfigured all count as error
      assign next_errmap[g] = std_missing[g] | std_wrong_type[g] | std_unconfigured[g];
      assign next_errmap[NUM_SLAVES+g] = b_missing[g] | b_wrong_type[g] | b_unconfigured[g];
    end
  endgenerate

  assign any_fault     = |errmap;
  // compare full map, so a slave swap still counts as a change
  assign state_differs = (errmap != reported_map);
  // outside protected mode slave events stay silent; reported history cleared
  assign fire = protected_mode && host_can_accept && !diag_irq && state_differs;

  // record bytes are little-end packed: byte n sits at bits 8n+7..8n
  assign record_flat = {`SDDR_RSVD_VAL,
                        errmap.b_slaves,
                        errmap.std_slaves,
                        `SDDR_FIX6_VAL, `SDDR_FIX5_VAL, `SDDR_FIX4_VAL,
                        base_diag_copy};

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      errmap <= `SDDR_ERR_RESET;
    end else begin
      errmap <= next_errmap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_irq       <= 1'b0;
      reported_map   <= `SDDR_ERR_RESET;
      reported_fault <= 1'b0;
      base_diag_copy <= `SDDR_DIAG_RESET;
    end else if (fire) begin
      diag_irq       <= 1'b1;
      reported_map   <= errmap;
      reported_fault <= any_fault;
      // group fault flag: 1 entering fault, 0 leaving it
      base_diag_copy <= {base_diag_extra, 7'h00, any_fault};
    end else if (!protected_mode) begin
      // leaving protected mode forgets the external history
      reported_map   <= `SDDR_ERR_RESET;
      reported_fault <= 1'b0;
      diag_irq       <= diag_irq & ~irq_ack;
    end else if (irq_ack) begin
      diag_irq <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req.valid;
      rd_data  <= record_flat[{rd_req.index, 3'b000} +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_fix4;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_FIX4) |=> (rd_data == 8'h60);
  endproperty
  a_fix4: assert property (p_fix4) else $error("byte four not 60");

  property p_fix6;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_FIX6) |=> (rd_data == 8'h40);
  endproperty
  a_fix6: assert property (p_fix6) else $error("byte six not 40");

  property p_rsvd;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_RSVD) |=> (rd_data == 8'h00);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte nonzero");

  property p_std_byte0;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_STD) |=> (rd_data == $past(errmap.std_slaves[7:0]));
  endproperty
  a_std_byte0: assert property (p_std_byte0) else $error("standard slave byte wrong");

  property p_b_byte0;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_BSL) |=> (rd_data == $past(errmap.b_slaves[7:0]));
  endproperty
  a_b_byte0: assert property (p_b_byte0) else $error("b slave byte wrong");

  property p_bit_follow;
    @(posedge sys_clk) disable iff (!reset_n)
      std_missing[0] |=> errmap.std_slaves[0];
  endproperty
  a_bit_follow: assert property (p_bit_follow) else $error("slave 0 error not taken");

  property p_no_irq_config;
    @(posedge sys_clk) disable iff (!reset_n)
      (!protected_mode && !diag_irq) |=> !diag_irq;
  endproperty
  a_no_irq_config: assert property (p_no_irq_config) else $error("irq outside protected mode");

  property p_no_repeat;
    @(posedge sys_clk) disable iff (!reset_n)
      (!diag_irq && errmap == reported_map && protected_mode) |=> !diag_irq;
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("irq without state change");

  property p_flag;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(diag_irq) |-> (base_diag_copy[0] == (|reported_map));
  endproperty
  a_flag: assert property (p_flag) else $error("group fault flag wrong");

  property p_fires;
    @(posedge sys_clk) disable iff (!reset_n)
      fire |=> diag_irq;
  endproperty
  a_fires: assert property (p_fires) else $error("interrupt not raised");

  property p_fix5;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_FIX5) |=> (rd_data == `SDDR_FIX5_VAL);
  endproperty
  a_fix5: assert property (p_fix5) else $error("byte five not 00");

  property p_base_byte0;
    @(posedge sys_clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.index == `SDDR_OFS_BASE) |=> (rd_data == $past(base_diag_copy[7:0]));
  endproperty
  a_base_byte0: assert property (p_base_byte0) else $error("base byte zero wrong");

  property p_rd_answer;
    @(posedge sys_clk) disable iff (!reset_n)
      rd_req.valid |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_rd_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
      !rd_req.valid |=> !rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without request");

  // a pending interrupt must not drop before the host has seen it
  property p_irq_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (diag_irq && !irq_ack) |=> diag_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped before ack");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (!reset_n)
      (diag_irq && irq_ack) |=> !diag_irq;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("interrupt held after ack");

  property p_extra;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(diag_irq) |-> (base_diag_copy[31:8] == $past(base_diag_extra));
  endproperty
  a_extra: assert property (p_extra) else $error("base bytes one to three not copied");

  property p_free_map;
    @(posedge sys_clk) disable iff (!reset_n)
      ($rose(diag_irq) && !base_diag_copy[0]) |-> (reported_map == `SDDR_ERR_RESET);
  endproperty
  a_free_map: assert property (p_free_map) else $error("fault-free report with map bits set");

  property p_b_follow;
    @(posedge sys_clk) disable iff (!reset_n)
      b_unconfigured[NUM_SLAVES-1] |=> errmap.b_slaves[NUM_SLAVES-1];
  endproperty
  a_b_follow: assert property (p_b_follow) else $error("top b slave error not taken");

  c_enter: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(diag_irq) && base_diag_copy[0]);
  c_leave: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(diag_irq) && !base_diag_copy[0]);
  c_read:  cover property (@(posedge sys_clk) disable iff (!reset_n) rd_valid && rd_data != 8'h00);
  c_reenter: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(protected_mode) ##1 $rose(diag_irq));
  c_defer: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(host_can_accept) ##1 $rose(diag_irq));
endmodule : sddr_record

// *** dv/sddr_host.sv ***
// host model: takes diagnostic interrupts, acknowledges them
// assumes one clock shared with the record block
`timescale 1ns/1ps
module sddr_host (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        diag_irq,
  input  wire logic [31:0] base_diag_copy,
  output logic             irq_ack,
  output logic [7:0]       irq_count,
  output logic             last_flag
);
  // ack one cycle late, like a slow handler
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack   <= 1'b0;
      irq_count <= 8'h00;
      last_flag <= 1'b0;
    end else begin
      irq_ack <= diag_irq && !irq_ack;
      if (diag_irq && !irq_ack) begin
        irq_count <= irq_count + 8'h01;
        last_flag <= base_diag_copy[0];
      end
    end
  end
endmodule : sddr_host

// *** dv/tb.sv ***
// testbench: record reads, interrupt sequence, mode gating
// assumes record block and host model compiled first
`timescale 1ns/1ps
module tb;
  logic        sys_clk, reset_n, prot, accept, irq_ack, diag_irq, rd_valid, last_flag;
  logic [31:0] std_miss, std_unc, b_wrong, std_wrong, b_miss, b_unc, base_diag_copy;
  logic [23:0] extra;
  logic [7:0]  rd_data, irq_count;
  sddr_pkg::sddr_read_req_type rd_req;
  int          errors, check_count, cycles;
  sddr_record dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .std_missing(std_miss), .std_wrong_type(std_wrong),
    .std_unconfigured(std_unc), .b_missing(b_miss), .b_wrong_type(b_wrong), .b_unconfigured(b_unc),
    .protected_mode(prot), .host_can_accept(accept), .irq_ack(irq_ack), .rd_req(rd_req),
    .base_diag_extra(extra), .diag_irq(diag_irq), .base_diag_copy(base_diag_copy), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sddr_host host_u (.sys_clk(sys_clk), .reset_n(reset_n), .diag_irq(diag_irq),
    .base_diag_copy(base_diag_copy), .irq_ack(irq_ack), .irq_count(irq_count), .last_flag(last_flag));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    @(posedge sys_clk) rd_req <= '{valid: 1'b1, index: idx};
    @(posedge sys_clk) rd_req <= '{valid: 1'b0, index: idx};
    #1 chk({31'h0, rd_valid}, 32'h1);
    chk({24'h0, rd_data}, {24'h0, exp});
  endtask : rd
  // fixed wait: map +1, irq +2, ack, with margin
  task automatic irq(input logic [7:0] exp);
    repeat (6) @(posedge sys_clk);
    #1 chk({24'h0, irq_count}, {24'h0, exp});
  endtask : irq
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic fixed_bytes;
    rd(4'h4, 8'h60);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'h40);
    rd(4'hf, 8'h00);
    rd(4'ha, 8'h00);
  endtask : fixed_bytes
  task automatic slave_events;
    @(posedge sys_clk) std_miss <= 32'h80;
    irq(8'h1);
    chk({31'h0, last_flag}, 32'h1);
    rd(4'h7, 8'h80);
    rd(4'h0, 8'h01);
    rd(4'h1, extra[7:0]);
    rd(4'h2, extra[15:8]);
    rd(4'h3, extra[23:16]);
    chk(base_diag_copy, {extra, 8'h01});
    @(posedge sys_clk) std_unc <= 32'h8000;
    irq(8'h2);
    rd(4'h8, 8'h80);
    @(posedge sys_clk) std_miss <= 32'h0;
    irq(8'h3);
    chk({31'h0, last_flag}, 32'h1);
    rd(4'h7, 8'h00);
    @(posedge sys_clk) std_unc <= 32'h0;
    irq(8'h4);
    chk({31'h0, last_flag}, 32'h0);
    rd(4'h8, 8'h00);
    @(posedge sys_clk) b_wrong <= 32'h0100_0008;
    irq(8'h5);
    rd(4'hb, 8'h08);
    rd(4'he, 8'h01);
    @(posedge sys_clk) b_wrong <= 32'h0;
    irq(8'h6);
  endtask : slave_events
  task automatic mode_gating;
    @(posedge sys_clk) prot <= 1'b0;
    std_miss <= 32'h4;
    irq(8'h6);
    @(posedge sys_clk) prot <= 1'b1;
    irq(8'h7);
    // brief drop and return while blocked stays unseen
    @(posedge sys_clk) accept <= 1'b0;
    std_miss <= 32'h0;
    irq(8'h7);
    @(posedge sys_clk) std_miss <= 32'h4;
    irq(8'h7);
    @(posedge sys_clk) accept <= 1'b1;
    irq(8'h7);
    @(posedge sys_clk) accept <= 1'b0;
    std_miss <= 32'h0;
    irq(8'h7);
    @(posedge sys_clk) accept <= 1'b1;
    irq(8'h8);
    chk({31'h0, last_flag}, 32'h0);
  endtask : mode_gating
  // the remaining error kinds, and the lowest and highest bit of a byte
  task automatic error_kinds;
    @(posedge sys_clk) std_wrong <= 32'h0000_0200;
    b_miss <= 32'h0001_0000;
    b_unc <= 32'h8000_0000;
    std_miss <= 32'h1;
    irq(8'h9);
    chk({31'h0, last_flag}, 32'h1);
    rd(4'h7, 8'h01);
    rd(4'h8, 8'h02);
    rd(4'hd, 8'h01);
    rd(4'he, 8'h80);
    @(posedge sys_clk) std_wrong <= 32'h0;
    b_miss <= 32'h0;
    b_unc <= 32'h0;
    std_miss <= 32'h0;
    irq(8'ha);
    chk(base_diag_copy, {extra, 8'h00});
    rd(4'he, 8'h00);
  endtask : error_kinds
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    reset_n = 1'b0;
    {std_miss, std_unc, b_wrong, std_wrong, b_miss, b_unc} = '0;
    extra = 24'h5a3c81;
    prot = 1'b1;
    accept = 1'b1;
    rd_req = '{valid: 1'b0, index: 4'h0};
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    fixed_bytes();
    slave_events();
    mode_gating();
    error_kinds();
    conclude();
  end
endmodule : tb
